// [logic/fes_host.sv]
// Host controller that issues erase command sequences to a byte-wide flash
// Contract
// - Block erase: unlock, unlock, 80h at 5555h
// - Sixth write of block erase carries 30h
// - Host issues extra confirms before timeout
// - Failure state held until read/reset
// - Chip erase: six writes, 10h sixth
// - Suspend is single B0h write, block erase
module fes_host
  import fes_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // Avalon-MM slave
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Flash pins
  output logic [19:0]      fl_addr,
  input  wire logic [7:0]  fl_dq_in,
  output logic [7:0]       fl_dq_out,
  output logic             fl_dq_oe,
  output logic             fl_chip_en_n,
  output logic             fl_write_en_n,
  output logic             fl_out_en_n,
  output logic             fl_reset_unprotect_pin_n,
  input  wire logic        fl_ready_busy_output
);

  // Sequence storage: up to six address/data writes per command
  logic [19:0]      seq_addr [6];
  logic [7:0]       seq_data [6];
  fes_state_e       state_r;
  logic [2:0]       idx_r;
  logic [2:0]       len_r;
  logic [CNT_W-1:0] cnt_r;
  logic [19:0]      blk_addr_r;
  logic [7:0]       rdata_r;
  logic             rd_op_r;
  logic [7:0]       dq_s1_r, dq_s2_r;
  logic             rb_s1_r, rb_s2_r;
  logic [19:0]      fl_addr_r;
  logic [7:0]       fl_dq_out_r;
  logic             oe_r, ce_n_r, we_n_r, re_n_r;
  logic [31:0]      avs_rd_r;
  logic             wait_r;
  logic             rp_n_r;
  logic             we_d_r;
  logic [2:0]       wr_seen_r;

  // Decode of the Avalon request; a write acts only on its acknowledge edge
  wire busy     = (state_r != FES_IDLE);
  wire ctrl_wr  = avs_write && !wait_r && avs_address == REG_CTRL && !busy;
  wire [2:0] op = avs_writedata[2:0];
  wire last_w   = (idx_r == len_r - 3'h1);
  wire cnt_done = (cnt_r == '0);

  // Command table: a full unlock sequence is built for every coded command
  function automatic logic [7:0] seq_byte(input logic [2:0] o, input logic [2:0] i);
    logic [7:0] b;
    b = 8'h00;
    case (i)
      3'h0: b = CMD_UNLOCK1;
      3'h1: b = CMD_UNLOCK2;
      3'h2: b = CMD_ERASE_SETUP;
      3'h3: b = CMD_UNLOCK1;
      3'h4: b = CMD_UNLOCK2;
      default: b = (o == OP_CHIP) ? CMD_CHIP_CONF : CMD_BLOCK_CONF;
    endcase
    return b;
  endfunction

  // Unlock cycles alternate between the two coded addresses
  function automatic logic [19:0] seq_adr(input logic [2:0] i, input logic [19:0] blk);
    logic [19:0] a;
    a = ADDR_UNLOCK1;
    case (i)
      3'h1, 3'h4: a = ADDR_UNLOCK2;
      3'h2:       a = ADDR_SETUP;
      3'h5:       a = blk;
      default:    a = ADDR_UNLOCK1;
    endcase
    return a;
  endfunction

  // Load a sequence on a control write; single cycles skip the unlock writes
  always_ff @(posedge sys_clk) begin
    if (ctrl_wr) begin
      for (int i = 0; i < 6; i++) begin
        seq_addr[i] <= seq_adr(3'(i), blk_addr_r);
        seq_data[i] <= seq_byte(op, 3'(i));
      end
      if (op == OP_ADDBLK) begin
        seq_addr[0] <= blk_addr_r; // Single write keeps inside the timeout
        seq_data[0] <= CMD_BLOCK_CONF;
      end else if (op == OP_SUSPEND) begin
        seq_addr[0] <= blk_addr_r;
        seq_data[0] <= CMD_SUSPEND;
      end else if (op == OP_RESET) begin
        seq_addr[0] <= blk_addr_r; // Read/reset leaves failed state
        seq_data[0] <= CMD_READ_RESET;
      end
    end
  end

  // Input pins pass two flops before use
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dq_s1_r <= 8'h00;
      dq_s2_r <= 8'h00;
      rb_s1_r <= 1'b1;
      rb_s2_r <= 1'b1;
    end else begin
      dq_s1_r <= fl_dq_in;
      dq_s2_r <= dq_s1_r;
      rb_s1_r <= fl_ready_busy_output;
      rb_s2_r <= rb_s1_r;
    end
  end

  // Pin sequencer: write pulses, or one read cycle per command for status polling
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= FES_IDLE;
      idx_r       <= 3'h0;
      len_r       <= 3'h0;
      cnt_r       <= '0;
      rd_op_r     <= 1'b0;
      fl_addr_r   <= RST_ADDR;
      fl_dq_out_r <= 8'h00;
      oe_r        <= 1'b0;
      ce_n_r      <= 1'b1;
      we_n_r      <= 1'b1;
      re_n_r      <= 1'b1;
      rdata_r     <= 8'h00;
    end else begin
      case (state_r)
        FES_IDLE: begin
          if (ctrl_wr && op != 3'h0 && op != 3'h7) begin
            idx_r   <= 3'h0;
            rd_op_r <= (op == OP_READ);
            len_r   <= (op == OP_BLOCK || op == OP_CHIP) ? 3'h6 : 3'h1;
            state_r <= FES_SETUP;
          end
        end
        FES_SETUP: begin
          ce_n_r <= 1'b0;
          if (rd_op_r) begin
            fl_addr_r <= blk_addr_r; // Reads return status after sixth write
            re_n_r    <= 1'b0;
            cnt_r     <= CNT_W'(T_ACC_CYC + 2);
            state_r   <= FES_RLOW;
          end else begin
            fl_addr_r   <= seq_addr[idx_r];
            fl_dq_out_r <= seq_data[idx_r];
            oe_r        <= 1'b1;
            we_n_r      <= 1'b0;
            cnt_r       <= CNT_W'(T_WP_CYC - 1);
            state_r     <= FES_WLOW;
          end
        end
        FES_WLOW: begin
          cnt_r <= cnt_r - CNT_W'(1);
          if (cnt_done) begin
            we_n_r  <= 1'b1; // Data latched by the device on this rise
            cnt_r   <= CNT_W'(T_WPH_CYC - 1);
            state_r <= FES_WHIGH;
          end
        end
        FES_WHIGH: begin
          cnt_r <= cnt_r - CNT_W'(1);
          if (cnt_done) begin
            idx_r <= idx_r + 3'h1;
            if (last_w) begin
              state_r <= FES_DONE;
            end else begin
              fl_addr_r   <= seq_addr[idx_r + 3'h1];
              fl_dq_out_r <= seq_data[idx_r + 3'h1];
              we_n_r      <= 1'b0;
              cnt_r       <= CNT_W'(T_WP_CYC - 1);
              state_r     <= FES_WLOW;
            end
          end
        end
        FES_RLOW: begin
          cnt_r <= cnt_r - CNT_W'(1);
          if (cnt_done) begin
            rdata_r <= dq_s2_r; // Two flops of latency covered by the count
            re_n_r  <= 1'b1;
            state_r <= FES_DONE;
          end
        end
        FES_DONE: begin
          oe_r    <= 1'b0;
          ce_n_r  <= 1'b1;
          state_r <= FES_IDLE;
        end
        default: state_r <= FES_IDLE;
      endcase
    end
  end

  // Register file: block address and a bus slave with one wait cycle
  wire [31:0] status_word = {16'h0000, rdata_r, 4'h0, 2'b00, rb_s2_r, busy};
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blk_addr_r <= RST_ADDR;
      avs_rd_r   <= 32'h0;
      wait_r     <= 1'b1;
    end else begin
      wait_r <= !(avs_read || avs_write) || !wait_r;
      if (avs_write && !wait_r && avs_address == REG_ADDR && !busy) begin
        blk_addr_r <= avs_writedata[19:0]; // Address carried by confirm
      end
      case (avs_address)
        REG_ADDR:   avs_rd_r <= {12'h000, blk_addr_r};
        REG_STATUS: avs_rd_r <= status_word;
        REG_RDATA:  avs_rd_r <= {24'h0, rdata_r};
        default:    avs_rd_r <= 32'h0;
      endcase
    end
  end

  assign avs_readdata             = avs_rd_r;
  assign avs_waitrequest          = wait_r;
  assign fl_addr                  = fl_addr_r;
  assign fl_dq_out                = fl_dq_out_r;
  assign fl_dq_oe                 = oe_r;
  assign fl_chip_en_n             = ce_n_r;
  assign fl_write_en_n            = we_n_r;
  assign fl_out_en_n              = re_n_r;
  assign fl_reset_unprotect_pin_n = rp_n_r;

  // Flash held in reset together with the controller, so both start clean
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp_n_r <= 1'b0;
    end else begin
      rp_n_r <= 1'b1;
    end
  end

  // Write pulses counted per chip-enable frame, checked when the frame closes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      we_d_r    <= 1'b1;
      wr_seen_r <= 3'h0;
    end else begin
      we_d_r <= fl_write_en_n;
      if (fl_chip_en_n) begin
        wr_seen_r <= 3'h0;
      end else if (we_d_r && !fl_write_en_n) begin
        wr_seen_r <= wr_seen_r + 3'h1;
      end
    end
  end

  // Checks on the pin sequence
  AST_WE_PULSE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $fell(fl_write_en_n) |-> !fl_write_en_n [*7]) else $error("write pulse too short");
  AST_NO_RW: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !(!fl_write_en_n && !fl_out_en_n)) else $error("read and write together");
  AST_OE_DATA: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !fl_write_en_n |-> fl_dq_oe && !fl_chip_en_n) else $error("write without drive");
  AST_SIX: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(fl_chip_en_n) |-> wr_seen_r == (rd_op_r ? 3'h0 : len_r))
    else $error("sequence length wrong");
  AST_SETUP: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($fell(fl_write_en_n) && len_r == 3'h6 && idx_r == 3'h2) |->
    fl_dq_out == CMD_ERASE_SETUP && fl_addr == ADDR_SETUP) else $error("setup code wrong");
  AST_CONF: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ($fell(fl_write_en_n) && len_r == 3'h6 && idx_r == 3'h5) |->
    (fl_dq_out == CMD_BLOCK_CONF || fl_dq_out == CMD_CHIP_CONF)) else $error("confirm code wrong");
  AST_STABLE: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!fl_write_en_n && !$fell(fl_write_en_n)) |-> $stable(fl_addr) && $stable(fl_dq_out))
    else $error("address moved during write");
  AST_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(fl_write_en_n) |-> fl_write_en_n [*4]) else $error("write high too short");
  COV_SIX: cover property (@(posedge sys_clk) state_r == FES_WHIGH && len_r == 3'h6 && last_w && cnt_done);
  COV_ONE: cover property (@(posedge sys_clk) state_r == FES_WHIGH && len_r == 3'h1 && cnt_done);
  COV_READ: cover property (@(posedge sys_clk) state_r == FES_RLOW && cnt_done);

endmodule : fes_host

// [logic/fes_pkg.sv]
// Package with constants for the flash erase sequencer host controller
package fes_pkg;
  // Command interface codes and addresses
  localparam logic [7:0]  CMD_UNLOCK1    = 8'haa;
  localparam logic [7:0]  CMD_UNLOCK2    = 8'h55;
  localparam logic [19:0] ADDR_UNLOCK1   = 20'h05555;
  localparam logic [19:0] ADDR_UNLOCK2   = 20'h02aaa;
  localparam logic [7:0]  CMD_ERASE_SETUP = 8'h80;
  localparam logic [19:0] ADDR_SETUP     = 20'h05555;
  localparam logic [7:0]  CMD_BLOCK_CONF = 8'h30;
  localparam logic [7:0]  CMD_CHIP_CONF  = 8'h10;
  localparam logic [7:0]  CMD_SUSPEND    = 8'hb0;
  localparam logic [7:0]  CMD_READ_RESET = 8'hf0;
  // Status bit positions
  localparam int POS_POLL   = 7;
  localparam int POS_TOGGLE = 6;
  localparam int POS_FAIL   = 5;
  localparam int POS_TIMER  = 3;
  localparam int POS_TOG2   = 2;
  // Avalon register offsets (word addresses)
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_ADDR   = 3'h1;
  localparam logic [2:0] REG_STATUS = 3'h2;
  localparam logic [2:0] REG_RDATA  = 3'h3;
  // Control register command field
  localparam logic [2:0] OP_BLOCK   = 3'h1;
  localparam logic [2:0] OP_ADDBLK  = 3'h2;
  localparam logic [2:0] OP_CHIP    = 3'h3;
  localparam logic [2:0] OP_SUSPEND = 3'h4;
  localparam logic [2:0] OP_RESET   = 3'h5;
  localparam logic [2:0] OP_READ    = 3'h6;
  // Bus timing: write pulse low, high, read access (ns)
  localparam int CLK_NS       = 10;
  localparam int T_WP_NS      = 65;
  localparam int T_WPH_NS     = 35;
  localparam int T_ACC_NS     = 150;
  localparam int T_WP_CYC     = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_WPH_CYC    = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
  localparam int T_ACC_CYC    = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int CNT_W        = 5;
  // Reset values
  localparam logic [19:0] RST_ADDR = 20'h00000;
  typedef enum logic [2:0] {FES_IDLE, FES_SETUP, FES_WLOW, FES_WHIGH, FES_RLOW, FES_DONE} fes_state_e;
endpackage : fes_pkg

// [sim/fes_flash_model.sv]
// Behavioural byte-wide flash that decodes the erase command sequences
module fes_flash_model
  import fes_pkg::*;
#(
  parameter int TMO = 300,
  parameter int ERS = 2000
) (
  input  wire logic        clk,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  din,
  output logic [7:0]       dout,
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic        inject_fail,
  output logic             rb
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0]  st = 2'd0; // 0 array, 1 timeout, 2 erasing, 3 failed
  int          n = 0;
  int          cnt = 0;
  logic        tg = 1'b0;
  logic [7:0]  last = 8'h00;
  logic [7:0]  sd [5] = '{CMD_UNLOCK1, CMD_UNLOCK2, CMD_ERASE_SETUP, CMD_UNLOCK1, CMD_UNLOCK2};
  logic [19:0] sa [5] = '{ADDR_UNLOCK1, ADDR_UNLOCK2, ADDR_SETUP, ADDR_UNLOCK1, ADDR_UNLOCK2};
  wire  [7:0]  stat = {st == 2'd3, tg, st == 2'd3, 1'b0, st[1], tg, 2'b00};
  wire  [7:0]  rd = (st == 2'd0) ? 8'hff : stat;
  assign rb = (st != 2'd2);
  // Released bus shows the inverse, never a stale match
  assign dout = (!ce_n && !oe_n) ? rd : ~last;
  logic        we_q = 1'b1;
  // One process owns the state: a command is decoded one clock after the
  // write strobe rises, while address and data still stand; else timeout, erase
  always @(posedge clk) begin
    we_q <= we_n;
    cnt <= cnt + 1;
    if (we_n && !we_q && !ce_n) begin
      if (st[1]) begin
        if (din == CMD_READ_RESET) st <= 2'd0;
      end else if (st == 2'd1 && din == CMD_BLOCK_CONF) cnt <= 0;
      else if (n == 5) begin
        n <= 0;
        cnt <= 0;
        if (din == CMD_BLOCK_CONF) st <= 2'd1;
        else if (din == CMD_CHIP_CONF) st <= 2'd2;
      end else n <= (din == sd[n] && addr == sa[n]) ? n + 1 : 0;
    end else if (st == 2'd1 && cnt >= TMO) begin
      st <= 2'd2;
      cnt <= 0;
    end else if (st == 2'd2 && cnt >= ERS) st <= inject_fail ? 2'd3 : 2'd0;
  end
  // Both toggles flip per read while busy
  always @(negedge oe_n) if (st == 2'd1 || st == 2'd2) tg <= !tg;
  always @(posedge oe_n) last <= rd;
endmodule // fes_flash_model

// [sim/tb_top.sv]
// Self-checking bench for the erase host controller
module tb_top;
  import fes_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q, s1;
  logic        avs_waitrequest, fl_dq_oe, fl_chip_en_n, fl_write_en_n, fl_out_en_n;
  logic        fl_reset_unprotect_pin_n, fl_ready_busy_output, fail_r = 1'b0;
  logic [19:0] fl_addr, ba;
  logic [7:0]  fl_dq_in, fl_dq_out;
  logic [28:0] got_q [$], exp_q [$];
  int          err_total = 0, compares = 0, seed = 63221;
  time         t0;
  fes_host DUT (.sys_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .fl_addr, .fl_dq_in, .fl_dq_out, .fl_dq_oe, .fl_chip_en_n, .fl_write_en_n,
    .fl_out_en_n, .fl_reset_unprotect_pin_n, .fl_ready_busy_output);
  fes_flash_model FLASH (.clk(sys_clk), .addr(fl_addr), .din(fl_dq_out), .dout(fl_dq_in),
    .ce_n(fl_chip_en_n), .we_n(fl_write_en_n), .oe_n(fl_out_en_n), .inject_fail(fail_r),
    .rb(fl_ready_busy_output));
  always #5 sys_clk = ~sys_clk;
  // Log every flash write seen on the pins
  always @(posedge fl_write_en_n) if (!fl_chip_en_n) got_q.push_back({fl_dq_oe, fl_addr, fl_dq_out});
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ev);
    compares++;
    if (seen !== ev) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, ev, seen);
    end
  endtask
  task bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  task op(input logic [2:0] c);
    bus(1'b1, REG_ADDR, {12'h0, ba});
    bus(1'b1, REG_CTRL, {29'h0, c});
  endtask
  // Poll status bounded; running out counts as a mismatch
  task wt(input int b, input logic v);
    int k;
    k = 0;
    do begin bus(1'b0, REG_STATUS, 32'h0); k++; end while (q[b] !== v && k < 2000);
    chk("status_wait", q[b], v);
  endtask
  task rds;
    op(OP_READ);
    wt(0, 1'b0);
    bus(1'b0, REG_RDATA, 32'h0);
  endtask
  task exs(input logic [7:0] c);
    exp_q.push_back({1'b1, ADDR_UNLOCK1, CMD_UNLOCK1});
    exp_q.push_back({1'b1, ADDR_UNLOCK2, CMD_UNLOCK2});
    exp_q.push_back({1'b1, ADDR_SETUP, CMD_ERASE_SETUP});
    exp_q.push_back({1'b1, ADDR_UNLOCK1, CMD_UNLOCK1});
    exp_q.push_back({1'b1, ADDR_UNLOCK2, CMD_UNLOCK2});
    exp_q.push_back({1'b1, ba, c});
  endtask
  task cmp_log;
    chk("write_count", got_q.size(), exp_q.size());
    while (exp_q.size() > 0 && got_q.size() > 0) chk("write", got_q.pop_front(), exp_q.pop_front());
    got_q.delete();
    exp_q.delete();
  endtask
  task test_done;
    $display("err_total %0d compares %0d", err_total, compares);
    if (err_total == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well past three erases
  initial begin
    #600000;
    err_total++;
    test_done;
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    chk("reset_pins", {fl_chip_en_n, fl_write_en_n, fl_out_en_n, fl_dq_oe, fl_reset_unprotect_pin_n}, 5'b11100);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    ba = 20'($random(seed));
    op(OP_BLOCK);
    chk("rp_high", fl_reset_unprotect_pin_n, 1'b1);
    wt(0, 1'b0);
    exs(CMD_BLOCK_CONF);
    cmp_log;
    ba = 20'($random(seed));
    t0 = $time;
    op(OP_ADDBLK);
    wt(0, 1'b0);
    exp_q.push_back({1'b1, ba, CMD_BLOCK_CONF});
    cmp_log;
    rds;
    chk("timeout_status", q[7:0] & 8'ha8, 8'h00);
    wt(1, 1'b0);
    chk("restart", ($time - t0) >= 3000, 1'b1);
    rds;
    s1 = q;
    rds;
    chk("erase_status", {s1[7], s1[5], s1[3]}, 3'b001);
    chk("toggles", {s1[6] ^ q[6], s1[2] ^ q[2]}, 2'b11);
    fail_r <= 1'b1;
    op(OP_CHIP);
    op(OP_SUSPEND);
    wt(0, 1'b0);
    exs(CMD_CHIP_CONF);
    cmp_log;
    chk("still_busy", q[1], 1'b0);
    wt(1, 1'b1);
    rds;
    s1 = q;
    rds;
    chk("fail_status", {q[7], q[5], s1[6] ^ q[6]}, 3'b110);
    op(OP_RESET);
    wt(0, 1'b0);
    exp_q.push_back({1'b1, ba, CMD_READ_RESET});
    cmp_log;
    rds;
    chk("array_read", q[7:0], 8'hff);
    fail_r <= 1'b0;
    op(OP_CHIP);
    wt(1, 1'b0);
    op(OP_SUSPEND);
    wt(0, 1'b0);
    exs(CMD_CHIP_CONF);
    exp_q.push_back({1'b1, ba, CMD_SUSPEND});
    cmp_log;
    wt(1, 1'b1);
    bus(1'b0, 3'h7, 32'h0);
    test_done;
  end
endmodule // tb_top
